/* File: include/hpr_consts.vh */
`ifndef HPR_CONSTS_VH
`define HPR_CONSTS_VH

`define HPR_IO_ADDR_W 16
`define HPR_DATA_W 8
`define HPR_CHAN_W 3
`define HPR_NUM_CHAN 8

`define HPR_PORT_CH0 16'h0487
`define HPR_PORT_CH1 16'h0483
`define HPR_PORT_CH2 16'h0481
`define HPR_PORT_CH3 16'h0482
`define HPR_PORT_CH5 16'h048B
`define HPR_PORT_CH6 16'h0489
`define HPR_PORT_CH7 16'h048A

`define HPR_PORT_LOW_PAGE_CH2 16'h0081

`define HPR_RESET_VAL 8'h00
`define HPR_UNMAPPED_VAL 8'h00
`define HPR_NO_REG_CHAN 3'h4
`define HPR_CHAN2 3'h2

`endif

/* File: tb/hpr_bank_properties.sv */
`timescale 1ns/100ps
module hpr_bank_properties
(
	input logic clock,
	input logic rst,
	input logic [15:0] io_addr,
	input logic io_wr,
	input logic io_rd,
	input logic [7:0] io_wdata,
	input logic [7:0] base_addr_wr,
	input logic [7:0] low_page_wr,
	input logic xfer_active,
	input logic [2:0] xfer_chan,
	input logic [7:0] io_rdata,
	input logic io_rd_hit,
	input logic [7:0] dma_addr_hi,
	input logic dma_addr_hi_valid
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_wr(a); io_wr && io_addr == a; endsequence
	sequence s_rd(a); io_rd && io_addr == a; endsequence
	chk_idle_read:
	assert property (!io_rd_hit |-> io_rdata == 8'h00) else $error("stray data");
	chk_read_hit:
	assert property (s_rd(16'h0489) |=> io_rd_hit) else $error("no hit");
	chk_read_back:
	assert property (s_wr(16'h0487) ##1 s_rd(16'h0487) |=> io_rdata == $past(io_wdata, 2))
		else $error("bad readback");
	chk_xfer_byte:
	assert property (s_wr(16'h0483) ##1 xfer_active && xfer_chan == 3'h1
		|=> dma_addr_hi == $past(io_wdata, 2)) else $error("bad byte");
	chk_xfer_valid:
	assert property (xfer_active && xfer_chan != 3'h4 |=> dma_addr_hi_valid) else $error("no valid");
	chk_xfer_idle:
	assert property (!(xfer_active && xfer_chan != 3'h4)
		|=> !dma_addr_hi_valid && dma_addr_hi == 8'h00) else $error("bad idle");
	chk_base_clear:
	assert property (base_addr_wr[3] && !io_wr ##1 s_rd(16'h0482) |=> io_rdata == 8'h00)
		else $error("no clear");
	chk_port_clear:
	assert property (s_wr(16'h0081) ##1 s_rd(16'h0481) |=> io_rdata == 8'h00) else $error("no clear");
endmodule // hpr_bank_properties

/* File: tb/hpr_high_page_bank_tb_top.sv */
`timescale 1ns/100ps
module hpr_high_page_bank_tb_top;
	logic clock = 0, rst = 1, io_wr = 0, io_rd = 0, xfer_active = 0, io_rd_hit, dma_addr_hi_valid;
	logic [15:0] io_addr = 16'h0000;
	logic [7:0] io_wdata = 8'h00, base_addr_wr = 8'h00, low_page_wr = 8'h00, io_rdata, dma_addr_hi;
	logic [2:0] xfer_chan = 3'h0;
	logic [15:0] ports [7] = '{16'h0481, 16'h0482, 16'h0483, 16'h0487, 16'h0489, 16'h048A, 16'h048B};
	int error_cnt = 0, n_tests = 0, cyc = 0;
	hpr_high_page_bank u_hpr_high_page_bank (.*);
	initial forever #20 clock = ~clock;
	always @(posedge clock)
	begin
		{io_wr, io_rd, base_addr_wr, low_page_wr} <= 18'h00000;
		if (++cyc == 500)
		begin
			error_cnt++;
			wrap_up;
		end
	end
	task chk(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e)
		begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clock);
		{io_addr, io_wdata, io_wr} = {a, d, 1'b1};
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e, input logic h = 1'b1);
		@(negedge clock);
		{io_addr, io_rd} = {a, 1'b1};
		@(negedge clock);
		chk(io_rdata, e);
		chk({7'h00, io_rd_hit}, {7'h00, h});
	endtask
	task pulse(input logic [7:0] b, input logic [7:0] l);
		@(negedge clock);
		{base_addr_wr, low_page_wr} = {b, l};
	endtask
	task xfer(input logic act, input logic [2:0] c, input logic [7:0] e, input logic v);
		@(negedge clock);
		{xfer_active, xfer_chan} = {act, c};
		@(negedge clock);
		chk(dma_addr_hi, e);
		chk({7'h00, dma_addr_hi_valid}, {7'h00, v});
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(negedge clock);
		rst = 0;
		for (int i = 0; i < 7; i++)
			rd(ports[i], 8'h00);
		$display("test reset done");
		for (int i = 0; i < 7; i++)
		begin
			wr(ports[i], 8'hA0 | i[7:0]);
			rd(ports[i], 8'hA0 | i[7:0]);
		end
		pulse(8'h18, 8'h00);
		rd(16'h0482, 8'h00);
		pulse(8'h00, 8'h20);
		rd(16'h048B, 8'h00);
		wr(16'h0081, 8'h77);
		rd(16'h0481, 8'h00);
		rd(16'h0483, 8'hA2);
		rd(16'h0489, 8'hA4);
		rd(16'h0480, 8'h00, 1'b0);
		pulse(8'h00, 8'h04);
		rd(16'h0481, 8'h00);
		pulse(8'h01, 8'h00);
		wr(16'h0487, 8'h5A);
		rd(16'h0487, 8'h5A);
		$display("test clear done");
		wr(16'h0483, 8'h3C);
		xfer(1'b1, 3'h1, 8'h3C, 1'b1);
		xfer(1'b1, 3'h4, 8'h00, 1'b0);
		xfer(1'b1, 3'h0, 8'h5A, 1'b1);
		xfer(1'b0, 3'h0, 8'h00, 1'b0);
		$display("test transfer done");
		wrap_up;
	end
endmodule // hpr_high_page_bank_tb_top
bind hpr_high_page_bank hpr_bank_properties u_hpr_bank_properties (.*);

/* File: verilog/hpr_high_page_bank.v */
`timescale 1ns/100ps
`include "hpr_consts.vh"

// Operation
// - active transfer of a channel other than 4 drives its stored byte on address bits 31..24 one cycle later.
// - a channel's base address write clears that channel's high page byte.
// - a write to low page port 81h clears channel 2's high page byte.
// - port 481h reads and writes channel 2's high page byte.
// - port 482h reads and writes channel 3, clearing like channel 2.
// - port 483h reads and writes channel 1, clearing like channel 2.
// - port 487h reads and writes channel 0, clearing like channel 2.
// - port 489h reads and writes channel 6, clearing like channel 2.
// - port 48Ah reads and writes channel 7, clearing like channel 2.
// - port 48Bh reads and writes channel 5, clearing like channel 2.
module hpr_high_page_bank
(
	input wire clock,
	input wire rst,
	input wire [15:0] io_addr,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_wdata,
	input wire [7:0] base_addr_wr,
	input wire [7:0] low_page_wr,
	input wire xfer_active,
	input wire [2:0] xfer_chan,
	output wire [7:0] io_rdata,
	output wire io_rd_hit,
	output wire [7:0] dma_addr_hi,
	output wire dma_addr_hi_valid
);

	reg [7:0] io_rdata_q;
	reg [7:0] io_rdata_d;
	reg io_rd_hit_q;
	reg io_rd_hit_d;
	reg [7:0] dma_addr_hi_q;
	reg [7:0] dma_addr_hi_d;
	reg dma_addr_hi_valid_q;
	reg dma_addr_hi_valid_d;
	reg [7:0] port_wr;
	reg [7:0] chan_clr;
	wire [3:0] wr_sel;
	wire [3:0] rd_sel;
	wire [63:0] page_flat;

	// port to channel decode: bit 3 set means hit, low bits the channel
	function [3:0] port_to_chan;
		input [15:0] addr;
		begin
			if (addr == `HPR_PORT_CH2)
				port_to_chan = {1'b1, 3'h2};
			else if (addr == `HPR_PORT_CH3)
				port_to_chan = {1'b1, 3'h3};
			else if (addr == `HPR_PORT_CH1)
				port_to_chan = {1'b1, 3'h1};
			else if (addr == `HPR_PORT_CH0)
				port_to_chan = {1'b1, 3'h0};
			else if (addr == `HPR_PORT_CH6)
				port_to_chan = {1'b1, 3'h6};
			else if (addr == `HPR_PORT_CH7)
				port_to_chan = {1'b1, 3'h7};
			else if (addr == `HPR_PORT_CH5)
				port_to_chan = {1'b1, 3'h5};
			else
				port_to_chan = 4'h0;
		end
	endfunction

	// pick one channel's byte out of the flattened bank
	function [7:0] pick_byte;
		input [63:0] flat;
		input [2:0] chan;
		begin
			pick_byte = flat[chan * 8 +: 8];
		end
	endfunction

	assign wr_sel = port_to_chan(io_addr);
	assign rd_sel = port_to_chan(io_addr);

	integer i;

	always @*
	begin
		port_wr = 8'h00;
		chan_clr = 8'h00;
		for (i = 0; i < `HPR_NUM_CHAN; i = i + 1)
		begin
			// per-channel clear, no cross-channel effect
			chan_clr[i] = base_addr_wr[i] | low_page_wr[i];
			if (io_wr && wr_sel[3] && (wr_sel[2:0] == i[2:0]))
				port_wr[i] = 1'b1;
		end
		if (io_wr && (io_addr == `HPR_PORT_LOW_PAGE_CH2))
			chan_clr[`HPR_CHAN2] = 1'b1;
		chan_clr[`HPR_NO_REG_CHAN] = 1'b0;
	end

	genvar g;
	generate
		for (g = 0; g < `HPR_NUM_CHAN; g = g + 1)
		begin : chan_gen
			if (g == 4)
			begin : no_reg
				assign page_flat[g * 8 +: 8] = `HPR_RESET_VAL;
			end
			else
			begin : has_reg
				hpr_page_cell u_cell
				(
					.clock(clock),
					.rst(rst),
					.wr_en(port_wr[g]),
					.clr_en(chan_clr[g]),
					.wr_data(io_wdata),
					.value(page_flat[g * 8 +: 8])
				);
			end
		end
	endgenerate

	always @*
	begin
		io_rd_hit_d = 1'b0;
		io_rdata_d = `HPR_UNMAPPED_VAL;
		if (io_rd && rd_sel[3])
		begin
			io_rd_hit_d = 1'b1;
			io_rdata_d = pick_byte(page_flat, rd_sel[2:0]);
		end
	end

	always @*
	begin
		dma_addr_hi_valid_d = 1'b0;
		dma_addr_hi_d = `HPR_RESET_VAL;
		if (xfer_active && (xfer_chan != `HPR_NO_REG_CHAN))
		begin
			dma_addr_hi_valid_d = 1'b1;
			dma_addr_hi_d = pick_byte(page_flat, xfer_chan);
		end
	end

	always @(posedge clock)
	begin
		if (rst)
		begin
			io_rdata_q <= `HPR_UNMAPPED_VAL;
			io_rd_hit_q <= 1'b0;
			dma_addr_hi_q <= `HPR_RESET_VAL;
			dma_addr_hi_valid_q <= 1'b0;
		end
		else
		begin
			io_rdata_q <= io_rdata_d;
			io_rd_hit_q <= io_rd_hit_d;
			dma_addr_hi_q <= dma_addr_hi_d;
			dma_addr_hi_valid_q <= dma_addr_hi_valid_d;
		end
	end

	assign io_rdata = io_rdata_q;
	assign io_rd_hit = io_rd_hit_q;
	assign dma_addr_hi = dma_addr_hi_q;
	assign dma_addr_hi_valid = dma_addr_hi_valid_q;

endmodule // hpr_high_page_bank

/* File: verilog/hpr_page_cell.v */
`timescale 1ns/100ps
`include "hpr_consts.vh"

// one channel's upper address byte
module hpr_page_cell
(
	input wire clock,
	input wire rst,
	input wire wr_en,
	input wire clr_en,
	input wire [7:0] wr_data,
	output wire [7:0] value
);

	reg [7:0] value_q;
	reg [7:0] value_d;

	always @*
	begin
		value_d = value_q;
		// software write wins over a clear in the same cycle
		if (wr_en)
			value_d = wr_data;
		else if (clr_en)
			value_d = `HPR_RESET_VAL;
	end

	always @(posedge clock)
	begin
		if (rst)
			value_q <= `HPR_RESET_VAL;
		else
			value_q <= value_d;
	end

	assign value = value_q;

endmodule // hpr_page_cell
